// file: bench/iopc_io_port_config_asserts.sv
`timescale 1ns/1ps
module iopc_io_port_config_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_cs,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rd_ack,
  input wire logic [7:0] mcu_data_to_port,
  input wire logic mcu_data_drive,
  input wire logic data_port_mode,
  input wire logic periph_select_a,
  input wire logic periph_select_b,
  input wire logic jtag_enable,
  input wire logic [7:0] jtag_oe,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pb_pt_oe,
  input wire logic [7:0] pb_addr_in,
  input wire logic [7:0] pc_oe,
  input wire logic [7:0] pc_addr_in,
  input wire logic [2:0] pd_in,
  input wire logic [7:0] capture_a
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence rd_req;
    bus_cs && bus_rd;
  endsequence
  sequence strobe_rise;
    $rose(pd_in[0]);
  endsequence
  a_rd_ack_next: assert property (rd_req |=> bus_rd_ack)
    else $error("read ack missing");
  a_ack_cause: assert property (bus_rd_ack |-> $past(bus_cs && bus_rd))
    else $error("read ack without request");
  a_rdata_hold: assert property (!bus_rd_ack |-> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_pt_oe_or: assert property (1'b1 |=> ((pb_oe[3:0] |
    ~$past(pb_pt_oe[3:0] & ~pb_addr_in[3:0])) == 4'hf))
    else $error("product term enable not honoured");
  a_addr_in_wins: assert property (1'b1 |=>
    (pb_oe & $past(pb_addr_in)) == 8'h00)
    else $error("address input pin driven");
  a_capture_take: assert property (strobe_rise |=>
    capture_a == $past(pa_in))
    else $error("strobe did not capture port a");
  a_capture_hold: assert property (!$rose(pd_in[0]) |=>
    $stable(capture_a))
    else $error("capture changed without strobe");
  a_data_port: assert property (data_port_mode && mcu_data_drive &&
    !periph_select_a && !periph_select_b |=>
    pa_oe == 8'hff && pa_out == $past(mcu_data_to_port))
    else $error("data port drive wrong");
  a_jtag_oe: assert property (jtag_enable && pc_addr_in == 8'h00 |=>
    pc_oe == $past(jtag_oe))
    else $error("programming enable not on port c");
  a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
    !rst_n |-> !bus_rd_ack && pa_oe == 8'h00 && pb_oe == 8'h00)
    else $error("outputs active in reset");
endmodule : iopc_io_port_config_asserts

// file: bench/iopc_pin_model.sv
`timescale 1ns/1ps
// Board pins with pull-ups; an undriven, unforced pin reads high.
module iopc_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_in
);
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else pin_in[i] = 1'b1;
    end
  end
endmodule : iopc_pin_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rst_n, bus_cs, bus_rd, bus_wr, bus_rd_ack;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, mcu_data_to_port, v;
  logic mcu_write_cycle, mcu_data_drive, data_port_mode, jtag_enable;
  logic periph_select_a, periph_select_b;
  logic [7:0] jtag_out, jtag_oe, lat_addr_a, lat_addr_b, port_a_to_mcu;
  logic [7:0] pa_in, pa_out, pa_oe, pa_slew_fast, pa_pt_oe, pa_pld_sel;
  logic [7:0] pa_pld_out, pa_addr_in, pb_in, pb_out, pb_oe, pb_slew_fast;
  logic [7:0] pb_pt_oe, pb_pld_sel, pb_pld_out, pb_addr_in, pc_in, pc_out;
  logic [7:0] pc_oe, pc_pt_oe, pc_pld_sel, pc_pld_out, pc_addr_in;
  logic [7:0] capture_a, capture_b, capture_c, ext_a;
  logic [2:0] pd_in, pd_out, pd_oe, pd_slew_fast, pd_pt_oe, pd_pld_sel;
  logic [2:0] pd_pld_out, pd_addr_in, ext_d, ext_d_en;
  int n_fail = 0;
  int check_count = 0;
  iopc_io_port_config iopc_io_port_config_inst (.*);
  iopc_pin_model pins_a (.pin_out(pa_out), .pin_oe(pa_oe), .ext_val(ext_a),
    .ext_en(8'hff), .pin_in(pa_in));
  iopc_pin_model pins_b (.pin_out(pb_out), .pin_oe(pb_oe), .ext_val(8'h00),
    .ext_en(8'h00), .pin_in(pb_in));
  iopc_pin_model pins_c (.pin_out(pc_out), .pin_oe(pc_oe), .ext_val(8'h00),
    .ext_en(8'h00), .pin_in(pc_in));
  iopc_pin_model #(.W(3)) pins_d (.pin_out(pd_out), .pin_oe(pd_oe),
    .ext_val(ext_d), .ext_en(ext_d_en), .pin_in(pd_in));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {bus_cs, bus_wr, bus_addr, bus_wdata} = {2'h3, a, d};
    @(negedge sys_clk);
    {bus_cs, bus_wr} = 2'h0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(negedge sys_clk);
    {bus_cs, bus_rd, bus_addr} = {2'h3, a};
    @(negedge sys_clk);
    {bus_cs, bus_rd} = 2'h0;
    n = 0;
    while (bus_rd_ack !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 4) begin
      n_fail++;
      $display("mismatch at %0t: read ack timed out", $time);
      final_report();
    end
    chk(bus_rdata, exp);
  endtask : rc
  task automatic settle;
    repeat (3) @(negedge sys_clk);
  endtask : settle
  task automatic done(input string s);
    $display("test %0s finished, mismatches so far %0d", s, n_fail);
  endtask : done
  initial begin
    rst_n = 1'b0;
    {ext_a, ext_d, ext_d_en} = {8'h3c, 6'h00};
    {bus_cs, bus_rd, bus_wr, mcu_write_cycle, mcu_data_drive} = '0;
    {data_port_mode, periph_select_a, periph_select_b, jtag_enable} = '0;
    {bus_addr, bus_wdata, mcu_data_to_port, jtag_out, jtag_oe} = '0;
    {lat_addr_a, lat_addr_b, pa_pt_oe, pa_pld_sel, pa_pld_out} = '0;
    {pa_addr_in, pb_pt_oe, pb_pld_sel, pb_pld_out, pb_addr_in} = '0;
    {pc_pt_oe, pc_pld_sel, pc_pld_out, pc_addr_in} = '0;
    {pd_pt_oe, pd_pld_sel, pd_pld_out, pd_addr_in} = '0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int p = 0; p < 4; p++) begin
      rc({p[3:0], 4'h2}, 8'h00);
      rc({p[3:0], 4'h6}, 8'h00);
      rc({p[3:0], 4'h8}, 8'h00);
      rc({p[3:0], 4'hc}, 8'h00);
    end
    rc(8'h50, 8'h00);
    done("reset");
    wr(8'h06, 8'h07);
    wr(8'h04, 8'h96);
    settle();
    rc(8'h06, 8'h07);
    rc(8'h04, 8'h96);
    rc(8'h0c, 8'h07);
    rc(8'h00, 8'h3e);
    chk(pa_oe, 8'h07);
    chk(pa_out & pa_oe, 8'h06);
    done("direction");
    wr(8'h36, 8'hff);
    wr(8'h38, 8'hff);
    wr(8'h34, 8'hfe);
    settle();
    rc(8'h36, 8'h07);
    rc(8'h38, 8'h07);
    rc(8'h34, 8'h06);
    chk({5'h0, pd_out}, 8'h06);
    chk({5'h0, pd_oe}, 8'h07);
    chk({5'h0, pd_slew_fast}, 8'h07);
    done("port d");
    wr(8'h22, 8'hff);
    rc(8'h22, 8'h00);
    lat_addr_a = 8'ha5;
    wr(8'h06, 8'hff);
    wr(8'h02, 8'h0f);
    settle();
    rc(8'h02, 8'h0f);
    chk(pa_out, 8'h95);
    wr(8'h02, 8'h00);
    done("address out");
    {pb_pt_oe, pb_pld_sel, pb_pld_out} = {8'h3c, 8'h3c, 8'h24};
    settle();
    chk(pb_oe, 8'h3c);
    chk(pb_out, 8'h24);
    pb_addr_in = 8'h04;
    settle();
    chk(pb_oe, 8'h38);
    pb_pt_oe = 8'h00;
    settle();
    chk(pb_oe, 8'h00);
    {pb_addr_in, pb_pld_sel} = 16'h0000;
    done("product term");
    wr(8'h08, 8'hff);
    wr(8'h18, 8'h0f);
    settle();
    chk(pa_slew_fast, 8'h0f);
    chk(pb_slew_fast, 8'h0f);
    chk(pa_oe, 8'h6f);
    chk(pa_out, 8'h06);
    wr(8'h08, 8'h00);
    settle();
    chk(pa_slew_fast, 8'h00);
    done("drive");
    {mcu_data_to_port, mcu_write_cycle, periph_select_a} = {8'h5a, 2'h3};
    wr(8'h40, 8'h80);
    settle();
    chk(pa_oe, 8'hff);
    chk(pa_out, 8'h5a);
    periph_select_a = 1'b0;
    settle();
    chk(pa_oe, 8'h00);
    {mcu_write_cycle, periph_select_b} = 2'h1;
    settle();
    chk(port_a_to_mcu, 8'h3c);
    periph_select_b = 1'b0;
    wr(8'h40, 8'h00);
    done("peripheral");
    data_port_mode = 1'b1;
    settle();
    chk(pa_oe, 8'h00);
    mcu_data_drive = 1'b1;
    settle();
    chk(pa_out, 8'h5a);
    {data_port_mode, mcu_data_drive} = 2'h0;
    done("data port");
    {jtag_out, jtag_oe, jtag_enable} = {16'ha5f0, 1'b1};
    settle();
    chk(pc_oe, 8'hf0);
    chk(pc_out & pc_oe, 8'ha0);
    jtag_enable = 1'b0;
    done("programming");
    wr(8'h06, 8'h00);
    settle();
    wr(8'h36, 8'h06);
    settle();
    chk(capture_a, 8'h3c);
    rc(8'h0a, 8'h3c);
    chk(capture_b, 8'hff);
    chk(capture_c, 8'hff);
    rc(8'h3a, 8'h00);
    {ext_d_en, ext_d} = {3'h1, 3'h0};
    settle();
    {ext_a, ext_d} = {8'hc3, 3'h1};
    settle();
    chk(capture_a, 8'hc3);
    done("capture");
    final_report();
  end
endmodule : testbench
bind iopc_io_port_config iopc_io_port_config_asserts
  iopc_io_port_config_asserts_inst (.*);

// file: design/iopc_addr_capture.sv
`timescale 1ns/1ps
module iopc_addr_capture #(
  parameter logic [7:0] CAP_MASK = 8'hff
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic strobe_rise,
  input wire logic [7:0] pin_in,
  output logic [7:0] captured
);
  logic [7:0] cap_r;
  logic [7:0] cap_nxt;
  assign cap_nxt = strobe_rise ? (pin_in & CAP_MASK) : cap_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= 8'h00;
    end else begin
      cap_r <= cap_nxt;
    end
  end
  assign captured = cap_r;
endmodule : iopc_addr_capture

// file: design/iopc_io_port_config.sv
`timescale 1ns/1ps
// What this block does
// - Mode bit 0 gives MCU I/O, 1 gives latched address out on A, B.
// - Only ports A and B have a mode register; C and D cannot.
// - Direction bit 1 makes an output, 0 an input; inputs by default.
// - Effective output enable is direction bit OR product-term enable.
// - With the product term idle or absent, direction bit alone decides.
// - Port D direction implements only its three low bits.
// - Mode, direction and drive registers clear to 00h at reset.
// - Register bit n governs pin n of the same port.
// - Drive bit 1 on open-drain capable pins selects open drain.
// - Drive bit 1 on slew capable pins selects fast slew.
// - Memory map bit 7 turns port A into a peripheral data buffer.
// - Peripheral buffer floats while neither peripheral select is active.
// - Port A as data bus port disables its general I/O use.
// - Port A, B and C inputs are captured on the address strobe from port D pin 0; port D capture reads 00h.
// - Port C pins are shared with programming when it is enabled.
// - MCU reads and writes all configuration registers by bus cycles.
// - Inputs used in memory select decode are kept as address inputs, except on port A in peripheral or data port use and port C in programming.
// - Enable readback shows 1 for driving pins, 0 for floating pins.
// - Data out drives enabled pins and stays readable.
// - A, B drive bits 7..4 open drain, 3..0 slew; C all open drain.
module iopc_io_port_config (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_cs,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rd_ack,
  input wire logic [7:0] mcu_data_to_port,
  input wire logic mcu_write_cycle,
  input wire logic mcu_data_drive,
  input wire logic data_port_mode,
  output logic [7:0] port_a_to_mcu,
  input wire logic periph_select_a,
  input wire logic periph_select_b,
  input wire logic jtag_enable,
  input wire logic [7:0] jtag_out,
  input wire logic [7:0] jtag_oe,
  input wire logic [7:0] lat_addr_a,
  input wire logic [7:0] lat_addr_b,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_slew_fast,
  input wire logic [7:0] pa_pt_oe,
  input wire logic [7:0] pa_pld_sel,
  input wire logic [7:0] pa_pld_out,
  input wire logic [7:0] pa_addr_in,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_slew_fast,
  input wire logic [7:0] pb_pt_oe,
  input wire logic [7:0] pb_pld_sel,
  input wire logic [7:0] pb_pld_out,
  input wire logic [7:0] pb_addr_in,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  input wire logic [7:0] pc_pt_oe,
  input wire logic [7:0] pc_pld_sel,
  input wire logic [7:0] pc_pld_out,
  input wire logic [7:0] pc_addr_in,
  input wire logic [2:0] pd_in,
  output logic [2:0] pd_out,
  output logic [2:0] pd_oe,
  output logic [2:0] pd_slew_fast,
  input wire logic [2:0] pd_pt_oe,
  input wire logic [2:0] pd_pld_sel,
  input wire logic [2:0] pd_pld_out,
  input wire logic [2:0] pd_addr_in,
  output logic [7:0] capture_a,
  output logic [7:0] capture_b,
  output logic [7:0] capture_c
);

  iopc_port_if pif [iopc_pkg::PORTS] ();

  logic [7:0] dout_r [iopc_pkg::PORTS];
  logic [7:0] dir_r [iopc_pkg::PORTS];
  logic [7:0] drive_r [iopc_pkg::PORTS];
  logic [7:0] mode_r [iopc_pkg::PORTS];
  logic [7:0] pin_out_r [iopc_pkg::PORTS];
  logic [7:0] pin_oe_r [iopc_pkg::PORTS];
  logic [7:0] slew_r [iopc_pkg::PORTS];
  logic [7:0] mem_map_r;
  logic [7:0] mem_map_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rd_ack_r;
  logic [7:0] to_mcu_r;
  logic [7:0] to_mcu_nxt;
  logic strobe_d_r;

  wire logic [7:0] pin_in [iopc_pkg::PORTS];
  wire logic [7:0] pt_oe [iopc_pkg::PORTS];
  wire logic [7:0] pld_sel [iopc_pkg::PORTS];
  wire logic [7:0] pld_out [iopc_pkg::PORTS];
  wire logic [7:0] addr_in [iopc_pkg::PORTS];
  wire logic [7:0] lat_addr [iopc_pkg::PORTS];
  wire logic [7:0] alt_sel [iopc_pkg::PORTS];
  wire logic [7:0] alt_out [iopc_pkg::PORTS];
  wire logic [7:0] alt_oe [iopc_pkg::PORTS];
  wire logic [7:0] captured [iopc_pkg::PORTS];
  wire logic [7:0] port_rdata [iopc_pkg::PORTS];

  wire logic [1:0] sel_port;
  wire logic [3:0] sel_reg;
  wire logic in_port_space;
  wire logic wr_cycle;
  wire logic rd_cycle;
  wire logic mem_map_hit;
  wire logic periph_on;
  wire logic periph_active;
  wire logic porta_taken;
  wire logic [7:0] jtag_sel;
  wire logic strobe_rise;
  wire logic port_d_pin_zero;

  assign pin_in[iopc_pkg::PA] = pa_in;
  assign pin_in[iopc_pkg::PB] = pb_in;
  assign pin_in[iopc_pkg::PC] = pc_in;
  assign pin_in[iopc_pkg::PD] = {5'h00, pd_in};
  assign pt_oe[iopc_pkg::PA] = pa_pt_oe;
  assign pt_oe[iopc_pkg::PB] = pb_pt_oe;
  assign pt_oe[iopc_pkg::PC] = pc_pt_oe;
  assign pt_oe[iopc_pkg::PD] = {5'h00, pd_pt_oe};
  assign pld_sel[iopc_pkg::PA] = pa_pld_sel;
  assign pld_sel[iopc_pkg::PB] = pb_pld_sel;
  assign pld_sel[iopc_pkg::PC] = pc_pld_sel;
  assign pld_sel[iopc_pkg::PD] = {5'h00, pd_pld_sel};
  assign pld_out[iopc_pkg::PA] = pa_pld_out;
  assign pld_out[iopc_pkg::PB] = pb_pld_out;
  assign pld_out[iopc_pkg::PC] = pc_pld_out;
  assign pld_out[iopc_pkg::PD] = {5'h00, pd_pld_out};
  assign addr_in[iopc_pkg::PA] = pa_addr_in;
  assign addr_in[iopc_pkg::PB] = pb_addr_in;
  assign addr_in[iopc_pkg::PC] = pc_addr_in;
  assign addr_in[iopc_pkg::PD] = {5'h00, pd_addr_in};
  assign lat_addr[iopc_pkg::PA] = lat_addr_a;
  assign lat_addr[iopc_pkg::PB] = lat_addr_b;
  assign lat_addr[iopc_pkg::PC] = 8'h00;
  assign lat_addr[iopc_pkg::PD] = 8'h00;

  assign sel_port = bus_addr[5:4];
  assign sel_reg = bus_addr[3:0];
  assign in_port_space = bus_addr[7:6] == iopc_pkg::PORT_SPACE;
  assign mem_map_hit = bus_addr == iopc_pkg::MEM_MAP_ADDR;
  assign wr_cycle = bus_cs & bus_wr;
  assign rd_cycle = bus_cs & bus_rd;

  assign periph_on = mem_map_r[iopc_pkg::MEM_MAP_PERIPH_BIT];
  assign periph_active = periph_select_a | periph_select_b;
  assign porta_taken = periph_on | data_port_mode;
  assign jtag_sel = jtag_enable ? iopc_pkg::JTAG_PIN_MASK : 8'h00;

  assign alt_sel[iopc_pkg::PA] = porta_taken ? 8'hff : 8'h00;
  assign alt_out[iopc_pkg::PA] = mcu_data_to_port;
  assign alt_oe[iopc_pkg::PA] =
    (periph_on ? (periph_active & mcu_write_cycle) : mcu_data_drive) ?
    8'hff : 8'h00;
  assign alt_sel[iopc_pkg::PB] = 8'h00;
  assign alt_out[iopc_pkg::PB] = 8'h00;
  assign alt_oe[iopc_pkg::PB] = 8'h00;
  assign alt_sel[iopc_pkg::PC] = jtag_sel;
  assign alt_out[iopc_pkg::PC] = jtag_out;
  assign alt_oe[iopc_pkg::PC] = jtag_oe;
  assign alt_sel[iopc_pkg::PD] = 8'h00;
  assign alt_out[iopc_pkg::PD] = 8'h00;
  assign alt_oe[iopc_pkg::PD] = 8'h00;

  assign port_d_pin_zero = pd_in[0];
  assign strobe_rise = port_d_pin_zero & ~strobe_d_r;

  genvar p;
  generate
    for (p = 0; p < iopc_pkg::PORTS; p++) begin : g_port
      wire logic port_hit;
      wire logic wr_hit;
      wire logic wr_dir;
      wire logic wr_drive;
      wire logic wr_mode;
      wire logic wr_dout;
      assign port_hit = in_port_space & (sel_port == 2'(p));
      assign wr_hit = wr_cycle & port_hit;
      assign wr_dir = wr_hit & (sel_reg == iopc_pkg::OFF_DIR);
      assign wr_drive = wr_hit & (sel_reg == iopc_pkg::OFF_DRIVE);
      assign wr_mode = wr_hit & (sel_reg == iopc_pkg::OFF_MODE);
      assign wr_dout = wr_hit & (sel_reg == iopc_pkg::OFF_DATA_OUT);

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_r[p] <= iopc_pkg::CFG_RESET;
        end else if (wr_dir) begin
          dir_r[p] <= bus_wdata & iopc_pkg::PIN_MASK[p];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          drive_r[p] <= iopc_pkg::CFG_RESET;
        end else if (wr_drive) begin
          drive_r[p] <= bus_wdata & iopc_pkg::PIN_MASK[p];
        end
      end

      // mode only on A and B
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mode_r[p] <= iopc_pkg::CFG_RESET;
        end else if (wr_mode) begin
          mode_r[p] <= bus_wdata & iopc_pkg::MODE_MASK[p];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          dout_r[p] <= iopc_pkg::CFG_RESET;
        end else if (wr_dout) begin
          dout_r[p] <= bus_wdata & iopc_pkg::PIN_MASK[p];
        end
      end

      assign pif[p].dout = dout_r[p];
      assign pif[p].dir = dir_r[p];
      assign pif[p].drive = drive_r[p];
      assign pif[p].mode = mode_r[p];
      assign pif[p].pt_oe = pt_oe[p];
      assign pif[p].lat_addr = lat_addr[p];
      assign pif[p].pld_sel = pld_sel[p];
      assign pif[p].pld_out = pld_out[p];
      assign pif[p].alt_sel = alt_sel[p];
      assign pif[p].alt_out = alt_out[p];
      assign pif[p].alt_oe = alt_oe[p];
      assign pif[p].in_only = addr_in[p] & ~alt_sel[p];

      iopc_port #(
        .PIN_MASK(iopc_pkg::PIN_MASK[p]),
        .MODE_MASK(iopc_pkg::MODE_MASK[p]),
        .OD_MASK(iopc_pkg::OD_MASK[p]),
        .SLEW_MASK(iopc_pkg::SLEW_MASK[p])
      ) u_port (
        .pif(pif[p])
      );

      iopc_addr_capture #(
        .CAP_MASK(iopc_pkg::CAP_MASK[p])
      ) u_cap (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .strobe_rise(strobe_rise),
        .pin_in(pin_in[p]),
        .captured(captured[p])
      );

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_out_r[p] <= 8'h00;
          pin_oe_r[p] <= 8'h00;
          slew_r[p] <= 8'h00;
        end else begin
          pin_out_r[p] <= pif[p].pin_out;
          pin_oe_r[p] <= pif[p].pin_oe;
          slew_r[p] <= pif[p].slew_fast;
        end
      end

      assign port_rdata[p] =
        (sel_reg == iopc_pkg::OFF_DATA_IN) ?
          (pin_in[p] & iopc_pkg::PIN_MASK[p]) :
        (sel_reg == iopc_pkg::OFF_MODE) ? mode_r[p] :
        (sel_reg == iopc_pkg::OFF_DATA_OUT) ? dout_r[p] :
        (sel_reg == iopc_pkg::OFF_DIR) ? dir_r[p] :
        (sel_reg == iopc_pkg::OFF_DRIVE) ? drive_r[p] :
        (sel_reg == iopc_pkg::OFF_CAPTURE) ? captured[p] :
        (sel_reg == iopc_pkg::OFF_OE_READ) ? pin_oe_r[p] :
        iopc_pkg::READ_NONE;
    end
  endgenerate

  assign rdata_nxt = !rd_cycle ? rdata_r :
                     in_port_space ? port_rdata[sel_port] :
                     mem_map_hit ? mem_map_r : iopc_pkg::READ_NONE;
  assign mem_map_nxt = (wr_cycle && mem_map_hit) ? bus_wdata : mem_map_r;
  assign to_mcu_nxt = (porta_taken && !mcu_write_cycle) ? pa_in : to_mcu_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_map_r <= iopc_pkg::CFG_RESET;
      rdata_r <= iopc_pkg::READ_NONE;
      rd_ack_r <= 1'b0;
      to_mcu_r <= 8'h00;
      // A strobe pin already high at reset is not taken as an edge.
      strobe_d_r <= 1'b1;
    end else begin
      mem_map_r <= mem_map_nxt;
      rdata_r <= rdata_nxt;
      rd_ack_r <= rd_cycle;
      to_mcu_r <= to_mcu_nxt;
      strobe_d_r <= port_d_pin_zero;
    end
  end

  assign bus_rdata = rdata_r;
  assign bus_rd_ack = rd_ack_r;
  assign port_a_to_mcu = to_mcu_r;
  assign capture_a = captured[iopc_pkg::PA];
  assign capture_b = captured[iopc_pkg::PB];
  assign capture_c = captured[iopc_pkg::PC];

  assign pa_out = pin_out_r[iopc_pkg::PA];
  assign pa_oe = pin_oe_r[iopc_pkg::PA];
  assign pa_slew_fast = slew_r[iopc_pkg::PA];
  assign pb_out = pin_out_r[iopc_pkg::PB];
  assign pb_oe = pin_oe_r[iopc_pkg::PB];
  assign pb_slew_fast = slew_r[iopc_pkg::PB];
  assign pc_out = pin_out_r[iopc_pkg::PC];
  assign pc_oe = pin_oe_r[iopc_pkg::PC];
  assign pd_out = pin_out_r[iopc_pkg::PD][2:0];
  assign pd_oe = pin_oe_r[iopc_pkg::PD][2:0];
  assign pd_slew_fast = slew_r[iopc_pkg::PD][2:0];

endmodule : iopc_io_port_config

// file: design/iopc_pkg.sv
package iopc_pkg;

  localparam int PORTS = 4;
  localparam int PA = 0;
  localparam int PB = 1;
  localparam int PC = 2;
  localparam int PD = 3;

  // Register offsets inside one port block.
  localparam logic [3:0] OFF_DATA_IN = 4'h0;
  localparam logic [3:0] OFF_MODE = 4'h2;
  localparam logic [3:0] OFF_DATA_OUT = 4'h4;
  localparam logic [3:0] OFF_DIR = 4'h6;
  localparam logic [3:0] OFF_DRIVE = 4'h8;
  localparam logic [3:0] OFF_CAPTURE = 4'ha;
  localparam logic [3:0] OFF_OE_READ = 4'hc;

  // Port blocks sit at 0x00, 0x10, 0x20, 0x30 of the I/O register space.
  localparam logic [1:0] PORT_SPACE = 2'h0;
  localparam logic [7:0] MEM_MAP_ADDR = 8'h40;
  localparam int MEM_MAP_PERIPH_BIT = 7;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Per-port capability masks, index 3 is port D.
  localparam logic [3:0][7:0] PIN_MASK = {8'h07, 8'hff, 8'hff, 8'hff};
  localparam logic [3:0][7:0] MODE_MASK = {8'h00, 8'h00, 8'hff, 8'hff};
  localparam logic [3:0][7:0] OD_MASK = {8'h00, 8'hff, 8'hf0, 8'hf0};
  localparam logic [3:0][7:0] SLEW_MASK = {8'h07, 8'h00, 8'h0f, 8'h0f};
  localparam logic [3:0][7:0] CAP_MASK = {8'h00, 8'hff, 8'hff, 8'hff};

  // Port C pins taken over while programming is enabled.
  localparam logic [7:0] JTAG_PIN_MASK = 8'hff;

endpackage : iopc_pkg

// file: design/iopc_port.sv
`timescale 1ns/1ps
module iopc_port #(
  parameter logic [7:0] PIN_MASK = 8'hff,
  parameter logic [7:0] MODE_MASK = 8'h00,
  parameter logic [7:0] OD_MASK = 8'h00,
  parameter logic [7:0] SLEW_MASK = 8'h00
) (
  iopc_port_if.pin pif
);
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      wire logic addr_mode;
      wire logic src;
      wire logic oe_req;
      wire logic open_drain;
      assign addr_mode = pif.mode[b] & MODE_MASK[b];
      assign src = pif.alt_sel[b] ? pif.alt_out[b] :
                   addr_mode ? pif.lat_addr[b] :
                   pif.pld_sel[b] ? pif.pld_out[b] : pif.dout[b];
      assign oe_req = ~pif.in_only[b] &
                      (pif.alt_sel[b] ? pif.alt_oe[b] :
                       (pif.dir[b] | pif.pt_oe[b]));
      assign open_drain = pif.drive[b] & OD_MASK[b];
      assign pif.pin_oe[b] = PIN_MASK[b] & oe_req & ~(open_drain & src);
      assign pif.pin_out[b] = PIN_MASK[b] & src & ~open_drain;
      assign pif.slew_fast[b] = PIN_MASK[b] & pif.drive[b] & SLEW_MASK[b];
    end
  endgenerate
endmodule : iopc_port

// file: design/iopc_port_if.sv
`timescale 1ns/1ps
interface iopc_port_if;
  logic [7:0] dout;
  logic [7:0] dir;
  logic [7:0] drive;
  logic [7:0] mode;
  logic [7:0] pt_oe;
  logic [7:0] lat_addr;
  logic [7:0] pld_sel;
  logic [7:0] pld_out;
  logic [7:0] alt_sel;
  logic [7:0] alt_out;
  logic [7:0] alt_oe;
  logic [7:0] in_only;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] slew_fast;
  modport cfg (
    output dout, dir, drive, mode, pt_oe, lat_addr, pld_sel, pld_out,
    output alt_sel, alt_out, alt_oe, in_only,
    input pin_out, pin_oe, slew_fast
  );
  modport pin (
    input dout, dir, drive, mode, pt_oe, lat_addr, pld_sel, pld_out,
    input alt_sel, alt_out, alt_oe, in_only,
    output pin_out, pin_oe, slew_fast
  );
endinterface : iopc_port_if
